// file: hw/pdc_top.sv
// programmable 4-bit bcd/binary down counter with apb control and status
// assumes: pins are asynchronous and slow against pclk (20 MHz); apb master on pclk
`include "pdc_map.svh"

// How it works
// RQ1: master_clear high forces the count to zero over every other input.
// RQ2: async_load high with clear low copies preset_inputs into the count continuously.
// RQ3: rising_count_clock edge steps only while falling_count_clock is low.
// RQ4: falling_count_clock edge steps only while rising_count_clock is high.
// RQ5: each step decrements by one, bcd or binary as selected.
// RQ6: terminal_count_out is high exactly at zero count with carry_forward_in high.
// RQ7: stepping from zero wraps to nine in bcd, fifteen in binary.
module pdc_top
   import pdc_pkg::*;
(
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic [`PDC_ADDR_W-1:0]    paddr,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [31:0]               pwdata,
   input  wire logic [3:0]                pstrb,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      master_clear,
   input  wire logic                      async_load,
   input  wire pdc_pkg::pdc_nib_t         preset_inputs,
   input  wire logic                      carry_forward_in,
   input  wire logic                      rising_count_clock,
   input  wire logic                      falling_count_clock,
   output pdc_pkg::pdc_nib_t              count_outputs,
   output logic                           terminal_count_out
);
   import pdc_pkg::*;

   pdc_pins_if pins ();

   pdc_sync u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .pins_raw ({master_clear, async_load, preset_inputs, carry_forward_in,
                  rising_count_clock, falling_count_clock}),
      .pins     (pins)
   );

   function automatic pdc_nib_t pdc_dec(input pdc_nib_t cur, input pdc_variant_t var_sel);
      pdc_nib_t res;
      if (cur == 4'h0) begin
         res = (var_sel == PDC_BCD) ? `PDC_BCD_TOP : `PDC_BIN_TOP;
      end else begin
         res = cur - 4'h1;
      end
      return res;
   endfunction : pdc_dec

   // counter state
   pdc_nib_t     count_ff;
   pdc_nib_t     nxt_count;
   logic         tc_ff;
   logic         nxt_tc;
   logic         rclk_d_ff;
   logic         nxt_rclk_d;
   logic         fclk_d_ff;
   logic         nxt_fclk_d;
   logic         rise_ev;
   logic         fall_ev;
   logic         step;

   // register file state
   pdc_variant_t variant_ff;
   pdc_variant_t nxt_variant;
   logic [31:0]  rdata_ff;
   logic [31:0]  nxt_rdata;
   logic         ready_ff;
   logic         nxt_ready;
   logic         err_ff;
   logic         nxt_err;
   logic         hit_ctrl;
   logic         hit_status;
   logic         wr_done;

   // a step needs both clock levels seen after the edge; pins are slow vs pclk
   always_comb begin
      nxt_rclk_d = pins.rising_count_clock;
      nxt_fclk_d = pins.falling_count_clock;
      rise_ev    = pins.rising_count_clock & ~rclk_d_ff & ~pins.falling_count_clock; // RQ3
      fall_ev    = ~pins.falling_count_clock & fclk_d_ff & pins.rising_count_clock;  // RQ4
      step       = rise_ev | fall_ev;
      if (pins.master_clear) begin
         nxt_count = `PDC_RST_COUNT; // RQ1
      end else if (pins.async_load) begin
         nxt_count = pins.preset_inputs; // RQ2
      end else if (step) begin
         nxt_count = pdc_dec(count_ff, variant_ff); // RQ5 RQ7
      end else begin
         nxt_count = count_ff;
      end
      nxt_tc = (nxt_count == 4'h0) & pins.carry_forward_in; // RQ6
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff  <= `PDC_RST_COUNT;
         tc_ff     <= 1'b0;
         rclk_d_ff <= 1'b0;
         fclk_d_ff <= 1'b0;
      end else begin
         count_ff  <= nxt_count;
         tc_ff     <= nxt_tc;
         rclk_d_ff <= nxt_rclk_d;
         fclk_d_ff <= nxt_fclk_d;
      end
   end

   assign count_outputs      = count_ff;
   assign terminal_count_out = tc_ff;

   // apb: one wait-free access cycle after setup; read data captured at setup
   always_comb begin
      hit_ctrl   = (paddr == `PDC_OFS_CTRL);
      hit_status = (paddr == `PDC_OFS_STATUS);
      wr_done    = psel & penable & ready_ff & pwrite;
      nxt_ready  = psel & ~penable;
      nxt_rdata  = rdata_ff;
      nxt_err    = err_ff;
      if (psel & ~penable) begin
         nxt_rdata = 32'h0000_0000;
         nxt_err   = ~(hit_ctrl | hit_status) | (pwrite & hit_status);
         if (!pwrite && hit_ctrl) begin
            nxt_rdata[`PDC_CTRL_BCD_BIT] = variant_ff;
         end
         if (!pwrite && hit_status) begin
            nxt_rdata[`PDC_STAT_CNT_LSB +: 4] = count_ff;
            nxt_rdata[`PDC_STAT_TC_BIT]       = tc_ff;
            nxt_rdata[`PDC_STAT_CF_BIT]       = pins.carry_forward_in;
            nxt_rdata[`PDC_STAT_MC_BIT]       = pins.master_clear;
            nxt_rdata[`PDC_STAT_LD_BIT]       = pins.async_load;
         end
      end
      nxt_variant = variant_ff;
      if (wr_done && hit_ctrl && pstrb[0]) begin
         nxt_variant = pdc_variant_t'(pwdata[`PDC_CTRL_BCD_BIT]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         variant_ff <= pdc_variant_t'(`PDC_RST_CTRL_BCD);
         rdata_ff   <= 32'h0000_0000;
         ready_ff   <= 1'b0;
         err_ff     <= 1'b0;
      end else begin
         variant_ff <= nxt_variant;
         rdata_ff   <= nxt_rdata;
         ready_ff   <= nxt_ready;
         err_ff     <= nxt_err;
      end
   end

   assign prdata  = rdata_ff;
   assign pready  = ready_ff;
   assign pslverr = err_ff;

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic mc_s;
   logic ld_s;
   logic cf_s;
   logic rc_s;
   logic fc_s;
   assign mc_s = pins.master_clear;
   assign ld_s = pins.async_load;
   assign cf_s = pins.carry_forward_in;
   assign rc_s = pins.rising_count_clock;
   assign fc_s = pins.falling_count_clock;

   sequence s_counting;
      !mc_s && !ld_s;
   endsequence

   sequence s_rise_ok;
      s_counting ##0 $rose(rc_s) && !fc_s;
   endsequence

   sequence s_fall_ok;
      s_counting ##0 $fell(fc_s) && rc_s;
   endsequence

   a_clear_wins: assert property (mc_s |=> count_outputs == 4'h0) // RQ1
      else $error("count not cleared under master clear");

   a_load_copies: assert property (!mc_s && ld_s |=> // RQ2
         count_outputs == $past(pins.preset_inputs))
      else $error("count does not follow preset under load");

   a_rise_steps: assert property (s_rise_ok |=> // RQ3
         count_outputs == pdc_dec($past(count_outputs), $past(variant_ff)))
      else $error("rising edge did not step the count");

   a_rise_blocked: assert property (s_counting ##0 $rose(rc_s) && fc_s && !$fell(fc_s) // RQ3
         |=> $stable(count_outputs))
      else $error("rising edge stepped while other clock high");

   a_fall_steps: assert property (s_fall_ok |=> // RQ4
         count_outputs == pdc_dec($past(count_outputs), $past(variant_ff)))
      else $error("falling edge did not step the count");

   a_idle_holds: assert property (s_counting ##0 $stable(rc_s) && $stable(fc_s) // RQ4
         |=> $stable(count_outputs))
      else $error("count moved without any clock edge");

   a_tc_tracks: assert property (##1 terminal_count_out == // RQ6
         (count_outputs == 4'h0 && $past(cf_s)))
      else $error("terminal count does not match zero and carry");

   a_zero_wraps: assert property ((s_rise_ok or s_fall_ok) ##0 count_outputs == 4'h0 // RQ5 RQ7
         |=> count_outputs == (($past(variant_ff) == PDC_BCD) ? 4'h9 : 4'hf))
      else $error("wrap from zero went to the wrong value");

endmodule : pdc_top

// file: common/pdc_map.svh
// register offsets, field positions, reset values of the down counter
// assumes: included by bare name from files that need the numbers
`ifndef PDC_MAP_SVH
`define PDC_MAP_SVH

`define PDC_ADDR_W        12
`define PDC_OFS_CTRL      12'h000
`define PDC_OFS_STATUS    12'h004

`define PDC_CTRL_BCD_BIT  0
`define PDC_RST_CTRL_BCD  1'b1

`define PDC_STAT_CNT_LSB  0
`define PDC_STAT_TC_BIT   4
`define PDC_STAT_CF_BIT   5
`define PDC_STAT_MC_BIT   6
`define PDC_STAT_LD_BIT   7

`define PDC_RST_COUNT     4'h0
`define PDC_BCD_TOP       4'h9
`define PDC_BIN_TOP       4'hf

`endif

// file: common/pdc_pkg.sv
// types shared by the down counter modules
// assumes: nothing beyond a sv compiler
package pdc_pkg;

   typedef logic [3:0] pdc_nib_t;

   typedef enum logic {
      PDC_BINARY = 1'b0,
      PDC_BCD    = 1'b1
   } pdc_variant_t;

endpackage : pdc_pkg

// file: common/pdc_pins_if.sv
// synchronised pin levels passed from the input synchroniser to the counter
// assumes: both ends run on pclk
interface pdc_pins_if;
   import pdc_pkg::*;

   logic     master_clear;
   logic     async_load;
   pdc_nib_t preset_inputs;
   logic     carry_forward_in;
   logic     rising_count_clock;
   logic     falling_count_clock;

   modport src (
      output master_clear,
      output async_load,
      output preset_inputs,
      output carry_forward_in,
      output rising_count_clock,
      output falling_count_clock
   );

   modport dst (
      input  master_clear,
      input  async_load,
      input  preset_inputs,
      input  carry_forward_in,
      input  rising_count_clock,
      input  falling_count_clock
   );

endinterface : pdc_pins_if

// file: hw/pdc_sync.sv
// two-flop synchronisers for all counter pins
// assumes: pins are asynchronous to pclk; reset is presetn, async, active low
module pdc_sync
   import pdc_pkg::*;
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic [8:0]    pins_raw,
   pdc_pins_if.src            pins
);

   logic [8:0] meta_ff;
   logic [8:0] sync_ff;
   logic [8:0] nxt_meta;
   logic [8:0] nxt_sync;

   // first stage feeds only the second stage
   always_comb begin
      nxt_meta = pins_raw;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= 9'h000;
         sync_ff <= 9'h000;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign pins.master_clear        = sync_ff[8];
   assign pins.async_load          = sync_ff[7];
   assign pins.preset_inputs       = sync_ff[6:3];
   assign pins.carry_forward_in    = sync_ff[2];
   assign pins.rising_count_clock  = sync_ff[1];
   assign pins.falling_count_clock = sync_ff[0];

endmodule : pdc_sync

// file: dv/pdc_ctl_model.sv
// outside control logic that drives the counter pins
// assumes: pclk from the bench; levels change just after a rising edge
module pdc_ctl_model
   import pdc_pkg::*;
(
   input  wire logic          pclk,
   output logic               master_clear,
   output logic               async_load,
   output pdc_pkg::pdc_nib_t  preset_inputs,
   output logic               carry_forward_in,
   output logic               rising_count_clock,
   output logic               falling_count_clock
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      master_clear = 1'b0;
      async_load = 1'b0;
      preset_inputs = 4'h0;
      carry_forward_in = 1'b0;
      rising_count_clock = 1'b0;
      falling_count_clock = 1'b0;
   end

   // 4 cycles per level: the pins are synchronised, so shorter levels may be lost
   task hold();
      repeat (4) @(posedge pclk);
   endtask : hold

   task pins(input logic mc, input logic ld, input pdc_nib_t p, input logic cf);
      master_clear <= mc;
      async_load <= ld;
      preset_inputs <= p;
      carry_forward_in <= cf;
      hold();
   endtask : pins

   // count clocks stand still between calls
   task clk(input logic r, input logic f);
      rising_count_clock <= r;
      falling_count_clock <= f;
      hold();
   endtask : clk

endmodule : pdc_ctl_model

// file: dv/tb_top.sv
// self-checking bench: apb register access plus pin-level counting scenarios
// assumes: pdc_top with its package, interface and map header
`include "pdc_map.svh"
module tb_top;
   import pdc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [`PDC_ADDR_W-1:0]  paddr;
   logic [31:0]             pwdata, prdata, rd;
   logic [3:0]              pstrb;
   logic                    master_clear, async_load, carry_forward_in, er;
   logic                    rising_count_clock, falling_count_clock, terminal_count_out;
   pdc_nib_t                preset_inputs, count_outputs;
   int                      bad_count, checks, cyc, i;

   pdc_top pdc_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .master_clear(master_clear), .async_load(async_load),
      .preset_inputs(preset_inputs), .carry_forward_in(carry_forward_in),
      .rising_count_clock(rising_count_clock), .falling_count_clock(falling_count_clock),
      .count_outputs(count_outputs), .terminal_count_out(terminal_count_out));

   pdc_ctl_model pdc_ctl_model_i (.pclk(pclk), .master_clear(master_clear),
      .async_load(async_load), .preset_inputs(preset_inputs),
      .carry_forward_in(carry_forward_in), .rising_count_clock(rising_count_clock),
      .falling_count_clock(falling_count_clock));

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task cnt(input logic [4:0] e);
      chk({27'h0, terminal_count_out, count_outputs}, {27'h0, e});
   endtask : cnt

   // no fixed wait: the slave's pready ends the access phase, a hang ends at the timeout
   task apb(input logic wr, input logic [`PDC_ADDR_W-1:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      chk(n, 32'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task conclude();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         conclude();
      end
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hf;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `PDC_OFS_CTRL, 32'h0);
      chk(rd, {31'h0, `PDC_RST_CTRL_BCD});
      apb(1'b0, `PDC_OFS_STATUS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      apb(1'b1, `PDC_OFS_STATUS, 32'hff);
      chk({31'h0, er}, 32'h1);
      $display("test registers done");
      pdc_ctl_model_i.pins(1'b0, 1'b1, 4'h3, 1'b0);
      cnt(5'h03);
      pdc_ctl_model_i.clk(1'b1, 1'b0);
      cnt(5'h03);
      pdc_ctl_model_i.clk(1'b0, 1'b0);
      pdc_ctl_model_i.pins(1'b0, 1'b0, 4'h3, 1'b0);
      $display("test load done");
      for (i = 2; i >= 0; i--) begin
         pdc_ctl_model_i.clk(1'b1, 1'b0);
         cnt(i[4:0]);
         pdc_ctl_model_i.clk(1'b0, 1'b0);
         cnt(i[4:0]);
      end
      pdc_ctl_model_i.pins(1'b0, 1'b0, 4'h0, 1'b1);
      cnt(5'h10);
      apb(1'b0, `PDC_OFS_STATUS, 32'h0);
      chk(rd, 32'h30);
      pdc_ctl_model_i.pins(1'b0, 1'b0, 4'h0, 1'b0);
      cnt(5'h00);
      pdc_ctl_model_i.clk(1'b1, 1'b0);
      cnt(5'h09);
      pdc_ctl_model_i.clk(1'b0, 1'b0);
      pdc_ctl_model_i.clk(1'b0, 1'b1);
      pdc_ctl_model_i.clk(1'b1, 1'b1);
      cnt(5'h09);
      pdc_ctl_model_i.clk(1'b1, 1'b0);
      cnt(5'h08);
      pdc_ctl_model_i.clk(1'b0, 1'b0);
      pdc_ctl_model_i.clk(1'b0, 1'b1);
      pdc_ctl_model_i.clk(1'b0, 1'b0);
      cnt(5'h08);
      $display("test counting done");
      apb(1'b1, `PDC_OFS_CTRL, 32'h0);
      pdc_ctl_model_i.pins(1'b0, 1'b1, 4'h0, 1'b0);
      pdc_ctl_model_i.pins(1'b0, 1'b0, 4'h0, 1'b0);
      pdc_ctl_model_i.clk(1'b1, 1'b0);
      cnt(5'h0f);
      pdc_ctl_model_i.clk(1'b0, 1'b0);
      pdc_ctl_model_i.clk(1'b1, 1'b0);
      cnt(5'h0e);
      pdc_ctl_model_i.clk(1'b0, 1'b0);
      $display("test binary done");
      pstrb <= 4'he;
      apb(1'b1, `PDC_OFS_CTRL, 32'h1);
      pstrb <= 4'hf;
      apb(1'b0, `PDC_OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      $display("test strobe done");
      pdc_ctl_model_i.pins(1'b1, 1'b1, 4'ha, 1'b1);
      cnt(5'h10);
      apb(1'b0, `PDC_OFS_STATUS, 32'h0);
      chk(rd, 32'hf0);
      pdc_ctl_model_i.clk(1'b1, 1'b0);
      cnt(5'h10);
      pdc_ctl_model_i.clk(1'b0, 1'b0);
      $display("test clear done");
      conclude();
   end

endmodule : tb_top
